// ---- core/pm_trap_timer_cfg.sv ----
// Trap and timer configuration: five control registers, two I/O trap
// comparators, the non-motherboard memory range match and four idle timers.
// Assumes bus cycles and register strobes are synchronous to ref_clk.
//
// How it works
// RULE_01 - Trap one control bit 7 masks address bits 15:10 of trap one.
// RULE_02 - Trap one control bit 6 excludes address bits 31:16 from trap one.
// RULE_03 - Trap one bits 4:2 give how many lowest address bits are ignored.
// RULE_04 - Trap two bits 4:2 give how many lowest address bits are ignored.
// RULE_05 - Trap two control bit 7 masks address bits 15:10 of trap two.
// RULE_06 - Trap two control bit 6 excludes address bits 31:16 from trap two.
// RULE_07 - Trap one bit 1 lets memory range hits wake the standby timer.
// RULE_08 - Trap one bit 0 lets memory range hits wake the suspend timer.
// RULE_09 - Trap two bit 1 lets memory range hits wake user timer one.
// RULE_10 - Trap two bit 0 lets memory range hits count for throttle.
// RULE_11 - Monitor bits 7:4 route trap one hits to standby, suspend, user1, throttle.
// RULE_12 - Monitor bits 3:0 route trap two hits to the same four timers.
// RULE_13 - Bits 7:4 of the count register pick the standby timeout.
// RULE_14 - Bits 3:0 of the count register pick the suspend timeout.
// RULE_15 - User register holds user one and two timeouts, suspend encoding.
// RULE_16 - All five control registers reset to zero.
// RULE_17 - A matching I/O access raises a system management interrupt pulse.
// RULE_18 - Memory range matches bits 31:16 against decode, except masked bits.
// RULE_19 - An enabled activity restarts its timer count.
// RULE_20 - Reserved bit 5 of both trap controls reads zero, writes ignored.
`timescale 1ns/1ps
module pm_trap_timer_cfg
#(
    parameter int TICK_CYCLES = pm_trap_pkg::TICK_CYC
)
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    // Register port
    input  wire pm_trap_pkg::regReq_s   regReq,
    output logic [7:0]                  regRdata,
    // Monitored bus cycle and programmed addresses
    input  wire pm_trap_pkg::busCycle_s busCycle,
    input  wire logic [31:0]            trapAddr1,
    input  wire logic [31:0]            trapAddr2,
    input  wire logic [15:0]            memDecode,
    input  wire logic [15:0]            memMask,
    // Events
    output logic                        smiPulse,
    output pm_trap_pkg::activity_s      activity,
    output logic [3:0]                  timerExpired
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]                           trap1Ctl;
        logic [7:0]                           trap2Ctl;
        logic [7:0]                           trapMon;
        logic [7:0]                           stSuTc;
        logic [7:0]                           userTc;
        logic [7:0]                           status;
        logic [7:0]                           rdata;
        logic                                 smi;
        pm_trap_pkg::activity_s               act;
        logic [3:0]                           expired;
        logic [pm_trap_pkg::DIV_W-1:0]        divCnt;
        logic [3:0][pm_trap_pkg::TC_W-1:0]    cnt;
    } state_s;

    state_s stateQ;
    state_s stateD;

    localparam logic [pm_trap_pkg::DIV_W-1:0] DIV_LAST =
        pm_trap_pkg::DIV_W'(TICK_CYCLES - 1);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Builds the ignore mask of one trap from its control byte
    function automatic logic [31:0] trapMask(input logic [7:0] ctl);
        logic [31:0] m;
        m = ~(pm_trap_pkg::LOW_ONES << ctl[pm_trap_pkg::LOW_SEL_MSB:pm_trap_pkg::LOW_SEL_LSB])
            & pm_trap_pkg::LOW_ONES;                                  // RULE_03 RULE_04
        if (ctl[pm_trap_pkg::BIT_HI_MASK])
        begin
            m = m | pm_trap_pkg::HI_FIELD;                           // RULE_01 RULE_05
        end
        if (ctl[pm_trap_pkg::BIT_UP_MASK])
        begin
            m = m | pm_trap_pkg::UP_FIELD;                           // RULE_02 RULE_06
        end
        return m;
    endfunction : trapMask

    // Compares an I/O cycle against one trap address
    function automatic logic trapHit(input pm_trap_pkg::busCycle_s c,
                                     input logic [31:0] ta, input logic [7:0] ctl);
        return c.valid && c.isIo && (((c.addr ^ ta) & ~trapMask(ctl)) == 32'h00000000);
    endfunction : trapHit

    // Looks up a timeout in ticks
    function automatic logic [pm_trap_pkg::TC_W-1:0] tcLookup(input logic [4:0] idx);
        return pm_trap_pkg::TC_TICKS[idx];
    endfunction : tcLookup

    // ----------------------------------------
    // Event decode
    // ----------------------------------------
    logic                                 hit1;
    logic                                 hit2;
    logic                                 memHit;
    pm_trap_pkg::activity_s               actNow;
    logic [3:0][pm_trap_pkg::TC_W-1:0]    termCnt;
    logic [3:0]                           restart;
    logic                                 tick;

    always_comb
    begin
        hit1   = trapHit(busCycle, trapAddr1, stateQ.trap1Ctl);
        hit2   = trapHit(busCycle, trapAddr2, stateQ.trap2Ctl);
        memHit = busCycle.valid && busCycle.isMem
                 && (((busCycle.addr[31:16] ^ memDecode) & ~memMask) == 16'h0000); // RULE_18
        actNow.standby  = (memHit && stateQ.trap1Ctl[pm_trap_pkg::BIT_MEM_A])   // RULE_07
                          || (hit1 && stateQ.trapMon[7])                        // RULE_11
                          || (hit2 && stateQ.trapMon[3]);                       // RULE_12
        actNow.suspend  = (memHit && stateQ.trap1Ctl[pm_trap_pkg::BIT_MEM_B])   // RULE_08
                          || (hit1 && stateQ.trapMon[6])                        // RULE_11
                          || (hit2 && stateQ.trapMon[2]);                       // RULE_12
        actNow.user1    = (memHit && stateQ.trap2Ctl[pm_trap_pkg::BIT_MEM_A])   // RULE_09
                          || (hit1 && stateQ.trapMon[5])                        // RULE_11
                          || (hit2 && stateQ.trapMon[1]);                       // RULE_12
        actNow.throttle = (memHit && stateQ.trap2Ctl[pm_trap_pkg::BIT_MEM_B])   // RULE_10
                          || (hit1 && stateQ.trapMon[4])                        // RULE_11
                          || (hit2 && stateQ.trapMon[0]);                       // RULE_12
        // Standby table is shifted by one step against the others
        termCnt[pm_trap_pkg::T_STBY] = tcLookup({1'b0, stateQ.stSuTc[7:4]} + 5'h01); // RULE_13
        termCnt[pm_trap_pkg::T_SUSP] = tcLookup({1'b0, stateQ.stSuTc[3:0]});    // RULE_14
        termCnt[pm_trap_pkg::T_USR1] = tcLookup({1'b0, stateQ.userTc[7:4]});    // RULE_15
        termCnt[pm_trap_pkg::T_USR2] = tcLookup({1'b0, stateQ.userTc[3:0]});    // RULE_15
        // User timer two has no activity source in this block
        restart = {1'b0, actNow.user1, actNow.suspend, actNow.standby};
        tick    = (stateQ.divCnt == DIV_LAST);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        stateD         = stateQ;
        stateD.rdata   = 8'h00;
        stateD.smi     = hit1 || hit2;                                   // RULE_17
        stateD.act     = actNow;
        stateD.expired = 4'h0;

        // Shared tick divider; a restart loses at most one tick of idle time
        stateD.divCnt = tick ? '0 : stateQ.divCnt + 1'b1;

        // Idle timers count ticks and restart on activity or expiry
        for (int i = 0; i < 4; i++)
        begin
            if (restart[i])
            begin
                stateD.cnt[i] = '0;                                      // RULE_19
            end
            else if (tick)
            begin
                if (stateQ.cnt[i] + 1'b1 >= termCnt[i])                  // RULE_13 RULE_14
                begin
                    stateD.cnt[i]     = '0;
                    stateD.expired[i] = 1'b1;
                end
                else
                begin
                    stateD.cnt[i] = stateQ.cnt[i] + 1'b1;
                end
            end
        end

        // Register writes; status is write-one-to-clear
        if (regReq.wr)
        begin
            unique case (regReq.addr)
                pm_trap_pkg::IDX_TRAP1_CTL: stateD.trap1Ctl = regReq.wdata & pm_trap_pkg::RSVD_KEEP; // RULE_20
                pm_trap_pkg::IDX_TRAP2_CTL: stateD.trap2Ctl = regReq.wdata & pm_trap_pkg::RSVD_KEEP; // RULE_20
                pm_trap_pkg::IDX_TRAP_MON:  stateD.trapMon  = regReq.wdata;
                pm_trap_pkg::IDX_STSU_TC:   stateD.stSuTc   = regReq.wdata;
                pm_trap_pkg::IDX_USER_TC:   stateD.userTc   = regReq.wdata;
                pm_trap_pkg::IDX_STATUS:    stateD.status   = stateQ.status & ~regReq.wdata;
                default:                    stateD.status   = stateQ.status;
            endcase
        end

        // Sticky events set after the clear so a same-cycle event survives
        stateD.status = stateD.status
                        | {1'b0, memHit, hit2, hit1, stateD.expired};

        // Read data stands one cycle after the strobe; unmapped reads zero
        if (regReq.rd)
        begin
            unique case (regReq.addr)
                pm_trap_pkg::IDX_TRAP1_CTL: stateD.rdata = stateQ.trap1Ctl;
                pm_trap_pkg::IDX_TRAP2_CTL: stateD.rdata = stateQ.trap2Ctl;
                pm_trap_pkg::IDX_TRAP_MON:  stateD.rdata = stateQ.trapMon;
                pm_trap_pkg::IDX_STSU_TC:   stateD.rdata = stateQ.stSuTc;
                pm_trap_pkg::IDX_USER_TC:   stateD.rdata = stateQ.userTc;
                pm_trap_pkg::IDX_STATUS:    stateD.rdata = stateQ.status;
                default:                    stateD.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Everything clears on reset: no masking, no monitoring, shortest counts
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stateQ <= '0;                                                // RULE_16
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    assign regRdata     = stateQ.rdata;
    assign smiPulse     = stateQ.smi;
    assign activity     = stateQ.act;
    assign timerExpired = stateQ.expired;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence ctl1Write;
        regReq.wr && regReq.addr == pm_trap_pkg::IDX_TRAP1_CTL;
    endsequence

    sequence ctl1Read;
        regReq.rd && regReq.addr == pm_trap_pkg::IDX_TRAP1_CTL;
    endsequence

    chk_ctl_readback: assert property (ctl1Write ##1 ctl1Read |=>        // RULE_20
        regRdata == ($past(regReq.wdata, 2) & pm_trap_pkg::RSVD_KEEP))
        else $error("trap one control readback wrong");

    chk_exact_trap: assert property (busCycle.valid && busCycle.isIo    // RULE_17
        && busCycle.addr == trapAddr1 |=> smiPulse)
        else $error("exact trap one address gave no interrupt");

    chk_high_mask: assert property (busCycle.valid && busCycle.isIo     // RULE_01
        && stateQ.trap1Ctl[7]
        && ((busCycle.addr ^ trapAddr1) & ~pm_trap_pkg::HI_FIELD) == 32'h00000000
        |=> smiPulse)
        else $error("bits 15:10 not masked for trap one");

    chk_upper_mask: assert property (busCycle.valid && busCycle.isIo    // RULE_02
        && !stateQ.trap1Ctl[6] && !stateQ.trap2Ctl[6]
        && (busCycle.addr[31:16] != trapAddr1[31:16])
        && (busCycle.addr[31:16] != trapAddr2[31:16]) |=> !smiPulse)
        else $error("upper bits ignored while not masked");

    chk_low_mask: assert property (busCycle.valid && busCycle.isIo      // RULE_03
        && ((busCycle.addr ^ trapAddr1) >> stateQ.trap1Ctl[4:2]) == 32'h00000000
        |=> smiPulse)
        else $error("low bits not masked for trap one");

    chk_trap_two: assert property (busCycle.valid && busCycle.isIo      // RULE_04 RULE_05 RULE_06
        && stateQ.trap2Ctl[7:6] == 2'b11
        && (((busCycle.addr ^ trapAddr2) & 32'h000003FF) >> stateQ.trap2Ctl[4:2])
           == 32'h00000000 |=> smiPulse)
        else $error("trap two masking wrong");

    chk_mem_standby: assert property (busCycle.valid && busCycle.isMem  // RULE_07 RULE_18
        && (busCycle.addr[31:16] | memMask) == (memDecode | memMask) && stateQ.trap1Ctl[1]
        |=> activity.standby)
        else $error("memory hit did not wake standby");

    chk_mem_quiet: assert property (busCycle.valid && !busCycle.isIo    // RULE_08 RULE_09 RULE_10
        && stateQ.trap1Ctl[1:0] == 2'b00 && stateQ.trap2Ctl[1:0] == 2'b00
        |=> activity == '0)
        else $error("disabled memory detection raised activity");

    chk_mon_route: assert property (busCycle.valid && !busCycle.isMem   // RULE_11 RULE_12
        && stateQ.trapMon == 8'h00 |=> activity == '0)
        else $error("unmonitored trap raised activity");

    chk_timer_restart: assert property (restart[pm_trap_pkg::T_STBY]    // RULE_19
        |=> stateQ.cnt[pm_trap_pkg::T_STBY] == '0 ##1 !timerExpired[pm_trap_pkg::T_STBY])
        else $error("activity did not restart standby count");

    chk_timer_expire: assert property (tick && !restart[pm_trap_pkg::T_SUSP] // RULE_14 RULE_15
        && stateQ.cnt[pm_trap_pkg::T_SUSP] + 1'b1 >= termCnt[pm_trap_pkg::T_SUSP]
        |=> timerExpired[pm_trap_pkg::T_SUSP])
        else $error("suspend timer missed its terminal count");

    chk_reset_zero: assert property ($rose(resetn) |->                  // RULE_16
        stateQ.trap1Ctl == 8'h00 && stateQ.trapMon == 8'h00 && stateQ.userTc == 8'h00)
        else $error("control registers not zero after reset");

endmodule : pm_trap_timer_cfg

// ---- inc/pm_trap_pkg.sv ----
// Constants, register map and carriers of the trap and timer configuration.
// Assumes one 20 MHz clock and an 8-bit indexed register port.
package pm_trap_pkg;

    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [7:0] IDX_TRAP1_CTL = 8'h5C;
    localparam logic [7:0] IDX_TRAP2_CTL = 8'h5D;
    localparam logic [7:0] IDX_TRAP_MON  = 8'h5E;
    localparam logic [7:0] IDX_STSU_TC   = 8'h5F;
    localparam logic [7:0] IDX_USER_TC   = 8'h60;
    localparam logic [7:0] IDX_STATUS    = 8'h68;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int         BIT_HI_MASK   = 7;
    localparam int         BIT_UP_MASK   = 6;
    localparam int         BIT_RSVD      = 5;
    localparam int         LOW_SEL_MSB   = 4;
    localparam int         LOW_SEL_LSB   = 2;
    localparam int         BIT_MEM_A     = 1;
    localparam int         BIT_MEM_B     = 0;
    localparam logic [7:0] RSVD_KEEP     = 8'hDF;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [31:0] HI_FIELD     = 32'h0000FC00;
    localparam logic [31:0] UP_FIELD     = 32'hFFFF0000;
    localparam logic [31:0] LOW_ONES     = 32'h000000FF;

    // ----------------------------------------
    // Timing: one timeout tick is 100 ms
    // ----------------------------------------
    localparam int TICK_MS    = 100;
    localparam int CLK_KHZ    = 20000;
    localparam int TICK_CYC   = TICK_MS * CLK_KHZ;
    localparam int DIV_W      = 24;
    localparam int TC_W       = 18;

    // Timeouts in ticks: suspend code c uses entry c, standby uses c+1
    localparam logic [TC_W-1:0] TC_TICKS [0:16] = '{
        18'h00002, 18'h00004, 18'h0000A, 18'h00012, 18'h00023, 18'h00046,
        18'h0008C, 18'h00118, 18'h00230, 18'h004B0, 18'h008E8, 18'h01194,
        18'h02328, 18'h04650, 18'h08CA0, 18'h11940, 18'h23280};

    // Timer slots
    localparam int T_STBY = 0;
    localparam int T_SUSP = 1;
    localparam int T_USR1 = 2;
    localparam int T_USR2 = 3;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic        valid;
        logic        isIo;
        logic        isMem;
        logic [31:0] addr;
    } busCycle_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } regReq_s;

    typedef struct packed {
        logic standby;
        logic suspend;
        logic user1;
        logic throttle;
    } activity_s;

endpackage : pm_trap_pkg

// ---- tb/pci_cycle_model.sv ----
// Stand-in for the host and bus masters: issues monitored PCI cycles.
// Assumes callers run in step with ref_clk; one cycle per call.
`timescale 1ns/1ps
module pci_cycle_model
(
    // Clock
    input  wire logic              ref_clk,
    // Monitored cycle toward the block
    output pm_trap_pkg::busCycle_s busCycle
);
    initial busCycle = '0;

    // Valid for one edge; released address lines flip so no stale value looks live
    task automatic issue(input logic isIo, input logic [31:0] addr);
        @(posedge ref_clk);
        busCycle <= '{valid: 1'b1, isIo: isIo, isMem: ~isIo, addr: addr};
        @(posedge ref_clk);
        busCycle <= '{valid: 1'b0, isIo: 1'b0, isMem: 1'b0, addr: ~addr};
    endtask : issue
endmodule : pci_cycle_model

// ---- tb/pm_trap_timer_cfg_tb.sv ----
// Self-checking bench for the trap and timer configuration block.
// Assumes a 20 MHz ref_clk and a timeout tick shortened to four clocks.
`timescale 1ns/1ps
module pm_trap_timer_cfg_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int          TICK  = 4;
    localparam int          LIMIT = 20000;
    localparam logic [31:0] TA1   = 32'h00000378;
    localparam logic [31:0] TA2   = 32'hABCD02F8;
    logic                   ref_clk;
    logic                   resetn;
    pm_trap_pkg::regReq_s   regReq;
    logic [7:0]             regRdata;
    pm_trap_pkg::busCycle_s busCycle;
    logic [31:0]            trapAddr1;
    logic [31:0]            trapAddr2;
    logic [15:0]            memDecode;
    logic [15:0]            memMask;
    logic                   smiPulse;
    pm_trap_pkg::activity_s activity;
    logic [3:0]             timerExpired;
    int                     n_errors = 0;
    int                     checks = 0;
    int                     cycles = 0;

    pm_trap_timer_cfg #(.TICK_CYCLES(TICK)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
        .regReq(regReq), .regRdata(regRdata), .busCycle(busCycle), .trapAddr1(trapAddr1),
        .trapAddr2(trapAddr2), .memDecode(memDecode), .memMask(memMask),
        .smiPulse(smiPulse), .activity(activity), .timerExpired(timerExpired));
    pci_cycle_model model_u (.ref_clk(ref_clk), .busCycle(busCycle));

    // ----------------------------------------
    // Clock, timeout and closing
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // A hang counts as a mismatch, then the normal closing runs
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Compares and bus tasks
    // ----------------------------------------
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check_byte

    task automatic check_int(input int got, input int exp, input string msg);
        checks++;
        if (got != exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask : check_int

    // Strobe launched after an edge, taken at the next one
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        regReq.wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        regReq.rd <= 1'b0;
        #1 d = regRdata;
    endtask : reg_read

    // Write, then read the same index with no gap between the strobes
    task automatic reg_write_read(input logic [7:0] a, input logic [7:0] w,
                                  output logic [7:0] d);
        @(posedge ref_clk);
        regReq <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        regReq.rd <= 1'b0;
        #1 d = regRdata;
    endtask : reg_write_read

    // Event outputs stand only in the cycle after the bus cycle is taken
    task automatic bus_check(input logic isIo, input logic [31:0] a, input logic expSmi,
                             input logic [3:0] expAct);
        model_u.issue(isIo, a);
        #1 check_byte({3'h0, smiPulse, activity}, {3'h0, expSmi, expAct}, "smi and activity");
    endtask : bus_check

    // Syncs to one expiry pulse, then counts clocks to the next
    // Looks just after the edge, so a pulse launched there is not missed
    task automatic measure(input int i, input int expCyc);
        int n;
        #1 n = 0;
        while (timerExpired[i] !== 1'b1 && n < 400)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1 n++;
        end while (timerExpired[i] !== 1'b1 && n < 400);
        check_int(n, expCyc, "timer period");
    endtask : measure

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_regs();
        logic [7:0] d;
        for (int i = 0; i < 5; i++)
        begin
            reg_read(8'h5C + 8'(i), d);
            check_byte(d, 8'h00, "reset value");
        end
        reg_write(8'h70, 8'hFF);
        reg_read(8'h70, d);
        check_byte(d, 8'h00, "unmapped index");
        for (int i = 0; i < 5; i++)
        begin
            reg_write_read(8'h5C + 8'(i), 8'hFF, d);
            check_byte(d, (i < 2) ? 8'hDF : 8'hFF, "readback");
            reg_write(8'h5C + 8'(i), 8'h00);
        end
        $display("test regs done");
    endtask : test_regs

    task automatic test_low_mask();
        logic [31:0] base;
        for (int t = 0; t < 2; t++)
            for (int n = 0; n < 8; n++)
            begin
                base = t ? TA2 : TA1;
                reg_write(8'h5C + 8'(t), 8'(n << 2));
                reg_write(pm_trap_pkg::IDX_TRAP_MON, t ? 8'h08 : 8'h80);
                bus_check(1'b1, base ^ ((32'h1 << n) - 32'h1), 1'b1, 4'h8);
                bus_check(1'b1, base ^ (32'h1 << n), 1'b0, 4'h0);
                reg_write(8'h5C + 8'(t), 8'h00);
            end
        $display("test low mask done");
    endtask : test_low_mask

    task automatic test_high_mask();
        logic [7:0]  ctl;
        logic [31:0] base;
        reg_write(pm_trap_pkg::IDX_TRAP_MON, 8'hFF);
        for (int t = 0; t < 2; t++)
            for (int k = 0; k < 4; k++)
            begin
                ctl = {2'(k), 6'h00};
                base = t ? TA2 : TA1;
                reg_write(8'h5C + 8'(t), ctl);
                bus_check(1'b1, base ^ 32'h0000FC00, ctl[7], {4{ctl[7]}});
                bus_check(1'b1, base ^ 32'hFFFF0000, ctl[6], {4{ctl[6]}});
                bus_check(1'b1, base ^ 32'h00000200, 1'b0, 4'h0);
                reg_write(8'h5C + 8'(t), 8'h00);
            end
        $display("test high mask done");
    endtask : test_high_mask

    task automatic test_monitor();
        for (int b = 0; b < 8; b++)
        begin
            reg_write(pm_trap_pkg::IDX_TRAP_MON, 8'h01 << b);
            bus_check(1'b1, TA1, 1'b1, (b >= 4) ? 4'(1 << (b - 4)) : 4'h0);
            bus_check(1'b1, TA2, 1'b1, (b < 4) ? 4'(1 << b) : 4'h0);
        end
        reg_write(pm_trap_pkg::IDX_TRAP_MON, 8'h00);
        $display("test monitor done");
    endtask : test_monitor

    task automatic test_mem();
        for (int e = 0; e < 16; e++)
        begin
            reg_write(pm_trap_pkg::IDX_TRAP1_CTL, {6'h00, 2'(e >> 2)});
            reg_write(pm_trap_pkg::IDX_TRAP2_CTL, {6'h00, 2'(e)});
            bus_check(1'b0, 32'h00C91234, 1'b0, 4'(e));
            bus_check(1'b0, 32'h00CA1234, 1'b0, 4'h0);
            bus_check(1'b1, 32'h00C81234, 1'b0, 4'h0);
        end
        reg_write(pm_trap_pkg::IDX_TRAP1_CTL, 8'h00);
        reg_write(pm_trap_pkg::IDX_TRAP2_CTL, 8'h00);
        $display("test mem done");
    endtask : test_mem

    // Ticks per code: suspend and user 0:2 1:4 2:10, standby 0:4 1:10 2:18
    task automatic test_timers();
        reg_write(pm_trap_pkg::IDX_STSU_TC, 8'h10);
        reg_write(pm_trap_pkg::IDX_USER_TC, 8'h21);
        measure(pm_trap_pkg::T_STBY, 10 * TICK);
        measure(pm_trap_pkg::T_SUSP, 2 * TICK);
        measure(pm_trap_pkg::T_USR1, 10 * TICK);
        measure(pm_trap_pkg::T_USR2, 4 * TICK);
        reg_write(pm_trap_pkg::IDX_STSU_TC, 8'h22);
        reg_write(pm_trap_pkg::IDX_USER_TC, 8'h10);
        measure(pm_trap_pkg::T_STBY, 18 * TICK);
        measure(pm_trap_pkg::T_SUSP, 10 * TICK);
        measure(pm_trap_pkg::T_USR1, 4 * TICK);
        measure(pm_trap_pkg::T_USR2, 2 * TICK);
        $display("test timers done");
    endtask : test_timers

    // Suspend at ten ticks, kept awake by memory hits every 22 clocks
    task automatic test_restart();
        int n;
        int hits;
        logic [7:0] d;
        reg_write(pm_trap_pkg::IDX_STSU_TC, 8'h02);
        reg_write(pm_trap_pkg::IDX_TRAP1_CTL, 8'h01);
        model_u.issue(1'b0, 32'h00C80000);
        hits = 0;
        repeat (6)
        begin
            repeat (20)
            begin
                @(posedge ref_clk);
                #1 hits += (timerExpired[1] === 1'b1) ? 1 : 0;
            end
            model_u.issue(1'b0, 32'h00C80000);
        end
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1 n++;
        end while (timerExpired[1] !== 1'b1 && n < 100);
        check_int(hits, 0, "expiry while active");
        check_int((n >= 36 && n <= 44) ? 1 : 0, 1, "expiry after quiet");
        reg_write(pm_trap_pkg::IDX_STATUS, 8'hFF);
        reg_read(pm_trap_pkg::IDX_STATUS, d);
        check_byte(d & 8'h70, 8'h00, "hit flags cleared");
        model_u.issue(1'b0, 32'h00C80000);
        reg_read(pm_trap_pkg::IDX_STATUS, d);
        check_byte(d & 8'h70, 8'h40, "memory hit flag");
        reg_write(pm_trap_pkg::IDX_TRAP1_CTL, 8'h00);
        $display("test restart done");
    endtask : test_restart

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        resetn = 1'b0;
        regReq = '0;
        trapAddr1 = TA1;
        trapAddr2 = TA2;
        memDecode = 16'h00C8;
        memMask = 16'h0001;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        test_regs();
        test_low_mask();
        test_high_mask();
        test_monitor();
        test_mem();
        test_timers();
        test_restart();
        complete_run();
    end
endmodule : pm_trap_timer_cfg_tb
